// File: design/mbm_engine.sv
/*
 Memory block move engine: copies, reversed copies, xor merges, receive
 FIFO to RAM moves and RAM to transmit FIFO copies.
 Assumes a synchronous RAM whose read data is valid one enabled cycle
 after the read strobe, and which is frozen by the same clock enable.
*/
// Notes on behaviour
// - Overlapping source and destination ranges give correct results, except in reversed copies longer than 16 bytes.
// - Shifting a block up by one byte leaves it intact at its new place.
// - Block copy moves bytes from source to destination in the same order.
// - Reversed copy sends source byte A+n to destination E+C-1-n.
// - Xor merge writes the xor of both blocks over the second block.
// - Xor merge with equal addresses writes zero into the whole block.
// - Receive move pops FIFO bytes into RAM starting at the destination.
// - Transmit copy pushes RAM bytes into the transmit FIFO, RAM unchanged.
// - Popping an empty receive FIFO raises underflow unless a byte arrives.
// - The receive FIFO holds up to 128 bytes and pops free the space.
`timescale 1ns/1ns
module mbm_engine #(
   parameter int AW      = mbm_pkg::ADDR_W,
   parameter int CW      = mbm_pkg::CNT_W,
   parameter int DW      = mbm_pkg::DATA_W,
   parameter int RXDEPTH = mbm_pkg::RX_DEPTH,
   parameter int REVMAX  = mbm_pkg::REV_LIMIT
) (
   input  wire logic                         clk_in,
   input  wire logic                         rst_in,
   input  wire logic                         ce_in,
   input  wire logic                         cmd_valid_in,
   output logic                              cmd_ready_out,
   input  wire mbm_pkg::mbm_op_e             cmd_op_in,
   input  wire logic [CW-1:0]                cmd_count_in,
   input  wire logic [AW-1:0]                cmd_src_in,
   input  wire logic [AW-1:0]                cmd_dst_in,
   output logic                              busy_out,
   output logic                              done_out,
   output logic      [AW-1:0]                ram_addr_out,
   output logic                              ram_rd_out,
   output logic                              ram_wr_out,
   output logic      [DW-1:0]                ram_wdata_out,
   input  wire logic [DW-1:0]                ram_rdata_in,
   output logic                              tx_valid_out,
   output logic      [DW-1:0]                tx_data_out,
   input  wire logic                         tx_ready_in,
   input  wire logic                         rx_valid_in,
   input  wire logic [DW-1:0]                rx_data_in,
   output logic                              rx_full_out,
   output logic      [$clog2(RXDEPTH+1)-1:0] rx_count_out,
   output logic                              rx_overflow_out,
   output logic                              rx_underflow_out
);
   typedef enum logic [2:0] {
      ST_IDLE, ST_RDA, ST_RDE, ST_LAT, ST_POP, ST_OUT, ST_WBUF, ST_DONE
   } mbm_st_e;

   mbm_st_e          st_q;
   mbm_pkg::mbm_op_e op_q;
   logic [CW-1:0]    cnt_q;
   logic [CW-1:0]    n_q;
   logic [AW-1:0]    src_q;
   logic [AW-1:0]    dst_q;
   logic             down_q;
   logic             rbuf_q;
   logic [DW-1:0]    a_q;
   logic [DW-1:0]    d_q;
   logic [DW-1:0]    buf_q [REVMAX];
   logic [CW-1:0]    k;
   logic             last;
   logic             fifo_pop;
   logic [DW-1:0]    fifo_data;

   function automatic logic [AW-1:0] addr_at(input logic [AW-1:0] base,
                                             input logic [CW-1:0] off);
      addr_at = AW'(base + AW'(off));
   endfunction

   function automatic logic [CW-1:0] mirror(input logic [CW-1:0] c,
                                            input logic [CW-1:0] n);
      mirror = CW'(c - 1'b1 - n);
   endfunction

   // Copies and xor merges walk downward when the destination lies above the source by less than the count
   assign k    = down_q ? mirror(cnt_q, n_q) : n_q;
   assign last = (n_q == CW'(cnt_q - 1'b1));
   assign fifo_pop = ce_in && (st_q == ST_POP);

   mbm_rx_fifo #(
      .DEPTH (RXDEPTH),
      .W     (DW)
   ) u_rx_fifo (
      .clk_in        (clk_in),
      .rst_in        (rst_in),
      .ce_in         (ce_in),
      .push_in       (rx_valid_in),
      .push_data_in  (rx_data_in),
      .pop_in        (fifo_pop),
      .pop_data_out  (fifo_data),
      .empty_out     (),
      .full_out      (rx_full_out),
      .count_out     (rx_count_out),
      .overflow_out  (rx_overflow_out),
      .underflow_out (rx_underflow_out)
   );

   assign cmd_ready_out = (st_q == ST_IDLE);
   assign busy_out      = (st_q != ST_IDLE);
   assign tx_valid_out  = (st_q == ST_OUT) && (op_q == mbm_pkg::OP_TXCP);
   assign tx_data_out   = d_q;

   always_comb begin
      ram_addr_out  = '0;
      ram_rd_out    = 1'b0;
      ram_wr_out    = 1'b0;
      ram_wdata_out = d_q;
      case (st_q)
         ST_RDA: begin
            ram_rd_out   = ce_in;
            ram_addr_out = (op_q == mbm_pkg::OP_REV) ? addr_at(src_q, n_q)
                         : addr_at(src_q, k);
         end
         ST_RDE: begin
            ram_rd_out   = ce_in;
            ram_addr_out = addr_at(dst_q, k);
         end
         ST_OUT: begin
            ram_wr_out   = ce_in && (op_q != mbm_pkg::OP_TXCP);
            ram_addr_out = (op_q == mbm_pkg::OP_REV)
                         ? addr_at(dst_q, mirror(cnt_q, n_q))
                         : addr_at(dst_q, k);
         end
         ST_WBUF: begin
            ram_wr_out    = ce_in;
            ram_addr_out  = addr_at(dst_q, mirror(cnt_q, n_q));
            ram_wdata_out = buf_q[n_q[$clog2(REVMAX)-1:0]];
         end
         default: begin
            ram_addr_out = '0;
         end
      endcase
   end

   // Command capture
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         op_q   <= mbm_pkg::OP_COPY;
         cnt_q  <= '0;
         src_q  <= '0;
         dst_q  <= '0;
         down_q <= 1'b0;
         rbuf_q <= 1'b0;
      end else if (ce_in && st_q == ST_IDLE && cmd_valid_in) begin
         op_q   <= cmd_op_in;
         cnt_q  <= cmd_count_in;
         src_q  <= cmd_src_in;
         dst_q  <= cmd_dst_in;
         // Distance taken modulo the RAM size so wrapped runs walk right
         down_q <= (cmd_op_in == mbm_pkg::OP_COPY ||
                    cmd_op_in == mbm_pkg::OP_XOR) &&
                   (AW'(cmd_dst_in - cmd_src_in) != '0) &&
                   (AW'(cmd_dst_in - cmd_src_in) <
                    AW'(cmd_count_in));
         // Short reversed copies are read whole before any write
         rbuf_q <= (cmd_op_in == mbm_pkg::OP_REV) &&
                   (cmd_count_in <= CW'(REVMAX));
      end
   end

   // Sequencer
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         st_q     <= ST_IDLE;
         n_q      <= '0;
         done_out <= 1'b0;
      end else if (ce_in) begin
         done_out <= 1'b0;
         case (st_q)
            ST_IDLE: begin
               n_q <= '0;
               if (cmd_valid_in) begin
                  if (cmd_count_in == '0) begin
                     st_q <= ST_DONE;
                  end else if (cmd_op_in == mbm_pkg::OP_RXMOV) begin
                     st_q <= ST_POP;
                  end else begin
                     st_q <= ST_RDA;
                  end
               end
            end
            ST_RDA: begin
               st_q <= (op_q == mbm_pkg::OP_XOR) ? ST_RDE : ST_LAT;
            end
            ST_RDE: begin
               st_q <= ST_LAT;
            end
            ST_LAT: begin
               if (!rbuf_q) begin
                  st_q <= ST_OUT;
               end else if (last) begin
                  n_q  <= '0;
                  st_q <= ST_WBUF;
               end else begin
                  n_q  <= n_q + 1'b1;
                  st_q <= ST_RDA;
               end
            end
            ST_POP: begin
               st_q <= ST_OUT;
            end
            ST_OUT: begin
               if (op_q != mbm_pkg::OP_TXCP || tx_ready_in) begin
                  if (last) begin
                     st_q <= ST_DONE;
                  end else begin
                     n_q  <= n_q + 1'b1;
                     st_q <= (op_q == mbm_pkg::OP_RXMOV) ? ST_POP : ST_RDA;
                  end
               end
            end
            ST_WBUF: begin
               if (last) begin
                  st_q <= ST_DONE;
               end else begin
                  n_q <= n_q + 1'b1;
               end
            end
            ST_DONE: begin
               done_out <= 1'b1;
               st_q     <= ST_IDLE;
            end
            default: begin
               st_q <= ST_IDLE;
            end
         endcase
      end
   end

   // Data path
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         a_q <= '0;
         d_q <= '0;
      end else if (ce_in) begin
         if (st_q == ST_RDE) begin
            a_q <= ram_rdata_in;
         end
         if (st_q == ST_LAT) begin
            d_q <= (op_q == mbm_pkg::OP_XOR) ? (a_q ^ ram_rdata_in)
                 : ram_rdata_in;
         end
         if (st_q == ST_POP) begin
            d_q <= fifo_data;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (ce_in && st_q == ST_LAT && rbuf_q) begin
         buf_q[n_q[$clog2(REVMAX)-1:0]] <= ram_rdata_in;
      end
   end

   AST_COPY_DOWN: assert property (@(posedge clk_in) disable iff (rst_in)
      ce_in && st_q == ST_RDA && op_q == mbm_pkg::OP_COPY && down_q
      |-> ram_addr_out == addr_at(src_q, mirror(cnt_q, n_q)))
      else $error("upward copy not walking down");
   AST_SHIFT_UP: assert property (@(posedge clk_in) disable iff (rst_in)
      ce_in && st_q == ST_IDLE && cmd_valid_in
      && cmd_op_in == mbm_pkg::OP_COPY && cmd_dst_in == cmd_src_in + 1'b1
      && cmd_count_in > CW'(1)
      |=> down_q)
      else $error("shift up chose wrong direction");
   AST_COPY_DATA: assert property (@(posedge clk_in) disable iff (rst_in)
      ce_in && st_q == ST_OUT && op_q == mbm_pkg::OP_COPY
      |-> ram_wr_out && ram_addr_out == addr_at(dst_q, k)
          && ram_wdata_out == d_q)
      else $error("copy write wrong");
   AST_REV_ADDR: assert property (@(posedge clk_in) disable iff (rst_in)
      ce_in && st_q == ST_WBUF
      |-> ram_addr_out == addr_at(dst_q, CW'(cnt_q - 1'b1 - n_q)))
      else $error("reversed address wrong");
   AST_XOR_RESULT: assert property (@(posedge clk_in) disable iff (rst_in)
      ce_in && st_q == ST_LAT && op_q == mbm_pkg::OP_XOR
      |=> d_q == $past(a_q ^ ram_rdata_in) && st_q == ST_OUT)
      else $error("xor result wrong");
   AST_XOR_SAME: assert property (@(posedge clk_in) disable iff (rst_in)
      ce_in && st_q == ST_OUT && op_q == mbm_pkg::OP_XOR && src_q == dst_q
      |-> ram_wr_out && ram_wdata_out == '0)
      else $error("self xor wrote nonzero");
   AST_RXMOV_POP: assert property (@(posedge clk_in) disable iff (rst_in)
      ce_in && st_q == ST_POP |-> fifo_pop ##1 st_q == ST_OUT)
      else $error("receive move pop wrong");
   AST_TX_NO_WRITE: assert property (@(posedge clk_in) disable iff (rst_in)
      op_q == mbm_pkg::OP_TXCP && busy_out |-> !ram_wr_out)
      else $error("transmit copy wrote RAM");
   AST_DONE_LAST: assert property (@(posedge clk_in) disable iff (rst_in)
      ce_in && st_q == ST_OUT && last && ram_wr_out
      |=> st_q == ST_DONE && !cmd_ready_out)
      else $error("done not after last byte");

   COV_COPY_DOWN: cover property (@(posedge clk_in)
      st_q == ST_OUT && op_q == mbm_pkg::OP_COPY && down_q && last);
   COV_REV_BUF: cover property (@(posedge clk_in) st_q == ST_WBUF && last);
   COV_XOR_DONE: cover property (@(posedge clk_in)
      done_out && op_q == mbm_pkg::OP_XOR);
   COV_TX_STALL: cover property (@(posedge clk_in)
      tx_valid_out && !tx_ready_in);
endmodule

// File: design/mbm_pkg.sv
/*
 Shared constants and types of the memory block move engine.
 Assumes a byte wide RAM of up to 1024 locations.
*/
package mbm_pkg;
   localparam int ADDR_W    = 10;
   localparam int CNT_W     = 8;
   localparam int DATA_W    = 8;
   localparam int RX_DEPTH  = 128;
   localparam int REV_LIMIT = 16;

   typedef enum logic [2:0] {
      OP_COPY,
      OP_REV,
      OP_XOR,
      OP_RXMOV,
      OP_TXCP
   } mbm_op_e;
endpackage

// File: design/mbm_rx_fifo.sv
/*
 Receive byte FIFO with overflow and underflow flags.
 Assumes push and pop come from logic on the same clock.
*/
`timescale 1ns/1ns
module mbm_rx_fifo #(
   parameter int DEPTH = mbm_pkg::RX_DEPTH,
   parameter int W     = mbm_pkg::DATA_W
) (
   input  wire logic                       clk_in,
   input  wire logic                       rst_in,
   input  wire logic                       ce_in,
   input  wire logic                       push_in,
   input  wire logic [W-1:0]               push_data_in,
   input  wire logic                       pop_in,
   output logic      [W-1:0]               pop_data_out,
   output logic                            empty_out,
   output logic                            full_out,
   output logic      [$clog2(DEPTH+1)-1:0] count_out,
   output logic                            overflow_out,
   output logic                            underflow_out
);
   localparam int PW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH+1);

   logic [W-1:0]  mem_q [DEPTH];
   logic [PW-1:0] wp_q;
   logic [PW-1:0] rp_q;
   logic [CW-1:0] cnt_q;
   logic          do_push;
   logic          do_pop;
   logic          bypass;

   assign empty_out = (cnt_q == '0);
   assign full_out  = (cnt_q == CW'(DEPTH));
   assign count_out = cnt_q;
   // Empty FIFO popped while a byte arrives hands the byte straight through
   assign bypass    = pop_in && push_in && empty_out;
   // A full FIFO still takes a byte when one leaves in the same cycle
   assign do_push   = push_in && (!full_out || pop_in) && !bypass;
   assign do_pop    = pop_in && !empty_out;
   assign pop_data_out = bypass ? push_data_in
                       : (empty_out ? '0 : mem_q[rp_q]);

   always_ff @(posedge clk_in) begin
      if (ce_in && do_push) begin
         mem_q[wp_q] <= push_data_in;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         wp_q  <= '0;
         rp_q  <= '0;
         cnt_q <= '0;
      end else if (ce_in) begin
         if (do_push) begin
            wp_q <= (wp_q == PW'(DEPTH-1)) ? '0 : wp_q + 1'b1;
         end
         if (do_pop) begin
            rp_q <= (rp_q == PW'(DEPTH-1)) ? '0 : rp_q + 1'b1;
         end
         cnt_q <= cnt_q + CW'(do_push) - CW'(do_pop);
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         overflow_out  <= 1'b0;
         underflow_out <= 1'b0;
      end else if (ce_in) begin
         overflow_out  <= push_in && full_out && !pop_in;
         underflow_out <= pop_in && empty_out && !push_in;
      end
   end

   AST_UNDERFLOW: assert property (@(posedge clk_in) disable iff (rst_in)
      ce_in && pop_in && empty_out |=> underflow_out == !$past(push_in))
      else $error("underflow flag wrong");
   AST_FIFO_LIMIT: assert property (@(posedge clk_in) disable iff (rst_in)
      cnt_q <= CW'(DEPTH))
      else $error("fifo count above depth");
endmodule

// File: dv/mbm_ram_model.sv
/*
 Behavioural byte RAM at the engine's memory port.
 Assumes the engine's one enabled cycle read latency and shared enable.
*/
`timescale 1ns/1ns
module mbm_ram_model (
   input  wire logic                        clk_in,
   input  wire logic                        ce_in,
   input  wire logic [mbm_pkg::ADDR_W-1:0]  addr_in,
   input  wire logic                        rd_in,
   input  wire logic                        wr_in,
   input  wire logic [mbm_pkg::DATA_W-1:0]  wdata_in,
   output logic      [mbm_pkg::DATA_W-1:0]  rdata_out
);
   logic [mbm_pkg::DATA_W-1:0] mem [1024];

   initial rdata_out = 8'h00;

   // Data follows the strobe by one enabled cycle, otherwise it scrambles
   always @(posedge clk_in) begin
      if (ce_in) begin
         if (wr_in) mem[addr_in] <= wdata_in;
         rdata_out <= rd_in ? mem[addr_in] : ~rdata_out;
      end
   end
endmodule

// File: dv/tb_mbm_engine.sv
/*
 Self-checking bench of the memory block move engine.
 Assumes the behavioural RAM model at the memory port.
*/
`timescale 1ns/1ns
module tb_mbm_engine;
   logic clk_in, rst_in, ce_in, cmd_valid_in, cmd_ready_out, busy_out;
   logic done_out, ram_rd_out, ram_wr_out, tx_valid_out, tx_ready_in;
   logic rx_valid_in, rx_full_out, rx_overflow_out, rx_underflow_out;
   mbm_pkg::mbm_op_e cmd_op_in;
   logic [7:0] cmd_count_in, ram_wdata_out, ram_rdata_in, tx_data_out;
   logic [7:0] rx_data_in, rx_count_out;
   logic [9:0] cmd_src_in, cmd_dst_in, ram_addr_out;
   logic [7:0] rm [1024];
   logic [7:0] rxq[$], txq[$], txe[$];
   int num_errors, tests_run, uf_seen, uf_exp, of_seen, of_exp, i, seed;

   mbm_engine uut (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in),
      .cmd_valid_in(cmd_valid_in), .cmd_ready_out(cmd_ready_out),
      .cmd_op_in(cmd_op_in), .cmd_count_in(cmd_count_in),
      .cmd_src_in(cmd_src_in), .cmd_dst_in(cmd_dst_in),
      .busy_out(busy_out), .done_out(done_out),
      .ram_addr_out(ram_addr_out), .ram_rd_out(ram_rd_out),
      .ram_wr_out(ram_wr_out), .ram_wdata_out(ram_wdata_out),
      .ram_rdata_in(ram_rdata_in), .tx_valid_out(tx_valid_out),
      .tx_data_out(tx_data_out), .tx_ready_in(tx_ready_in),
      .rx_valid_in(rx_valid_in), .rx_data_in(rx_data_in),
      .rx_full_out(rx_full_out), .rx_count_out(rx_count_out),
      .rx_overflow_out(rx_overflow_out),
      .rx_underflow_out(rx_underflow_out));

   mbm_ram_model ram (.clk_in(clk_in), .ce_in(ce_in),
      .addr_in(ram_addr_out), .rd_in(ram_rd_out), .wr_in(ram_wr_out),
      .wdata_in(ram_wdata_out), .rdata_out(ram_rdata_in));

   initial begin
      clk_in = 0;
      forever #10 clk_in = ~clk_in;
   end

   // Transmit sink with random stalls, flag counters
   always @(posedge clk_in) begin
      if (ce_in && tx_valid_out === 1'b1 && tx_ready_in)
         txq.push_back(tx_data_out);
      if (ce_in && rx_underflow_out === 1'b1) uf_seen++;
      if (ce_in && rx_overflow_out === 1'b1) of_seen++;
      #2 tx_ready_in = 1'($urandom % 2);
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
      end
   endtask

   task automatic report_and_stop();
      if (num_errors == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // Reference result of one command
   task automatic model(input mbm_pkg::mbm_op_e op, input int c, a, e);
      logic [7:0] s[$];
      int k;
      for (k = 0; k < c; k++) s.push_back(rm[(a + k) % 1024]);
      for (k = 0; k < c; k++) begin
         case (op)
            mbm_pkg::OP_COPY: rm[(e + k) % 1024] = s[k];
            mbm_pkg::OP_REV: rm[(e + c - 1 - k) % 1024] = s[k];
            mbm_pkg::OP_XOR: rm[(e + k) % 1024] ^= s[k];
            mbm_pkg::OP_RXMOV: begin
               if (rxq.size() > 0) rm[(e + k) % 1024] = rxq.pop_front();
               else begin
                  rm[(e + k) % 1024] = 8'h00;
                  uf_exp++;
               end
            end
            default: txe.push_back(s[k]);
         endcase
      end
   endtask

   task automatic run(input mbm_pkg::mbm_op_e op, input int c, a, e,
                      input bit rce);
      bit tk;
      int n;
      int m;
      @(posedge clk_in);
      #2 cmd_valid_in = 1;
      cmd_op_in = op;
      cmd_count_in = c[7:0];
      cmd_src_in = a[9:0];
      cmd_dst_in = e[9:0];
      do begin
         @(negedge clk_in);
         tk = ce_in && cmd_ready_out === 1'b1;
         @(posedge clk_in);
      end while (!tk);
      #2 cmd_valid_in = 0;
      check(busy_out, 1);
      n = 0;
      m = 0;
      while (done_out !== 1'b1 && n < 3000) begin
         if (rce) ce_in = ($urandom % 4) != 0;
         @(posedge clk_in);
         #2 n++;
         if (ce_in) m++;
      end
      ce_in = 1;
      if (n >= 3000) begin
         num_errors++;
         report_and_stop();
      end
      if (c == 0) check(m, 1);
      model(op, c, a, e);
      for (n = 0; n < 1024; n++)
         check(ram.mem[n], rm[n]);
      check(txq.size(), txe.size());
      while (txq.size() > 0 && txe.size() > 0)
         check(txq.pop_front(), txe.pop_front());
      check(uf_seen, uf_exp);
   endtask

   task automatic push_rx();
      @(posedge clk_in);
      #2 rx_valid_in = 1;
      rx_data_in = 8'($urandom);
      if (rxq.size() < 128) rxq.push_back(rx_data_in);
      else of_exp++;
      @(posedge clk_in);
      #2 rx_valid_in = 0;
   endtask

   initial begin
      #1_500_000;
      num_errors++;
      report_and_stop();
   end

   initial begin
      mbm_pkg::mbm_op_e op;
      int c, a, e;
      rst_in = 1;
      ce_in = 1;
      cmd_valid_in = 0;
      cmd_op_in = mbm_pkg::OP_COPY;
      cmd_count_in = 8'h00;
      cmd_src_in = 10'h000;
      cmd_dst_in = 10'h000;
      tx_ready_in = 0;
      rx_valid_in = 0;
      rx_data_in = 8'h00;
      seed = $urandom(40);
      for (i = 0; i < 1024; i++) begin
         rm[i] = 8'($urandom);
         ram.mem[i] = rm[i];
      end
      repeat (6) @(posedge clk_in);
      #2 rst_in = 0;
      run(mbm_pkg::OP_COPY, 9, 'h22a, 'h22b, 0);
      run(mbm_pkg::OP_COPY, 0, 'h005, 'h006, 0);
      run(mbm_pkg::OP_COPY, 40, 'h150, 'h140, 1);
      run(mbm_pkg::OP_REV, 16, 'h100, 'h104, 0);
      run(mbm_pkg::OP_XOR, 12, 'h300, 'h305, 0);
      run(mbm_pkg::OP_XOR, 20, 'h040, 'h040, 0);
      run(mbm_pkg::OP_TXCP, 24, 'h3f8, 'h000, 1);
      repeat (130) push_rx();
      @(posedge clk_in);
      #2;
      check(rx_count_out, 128);
      check(rx_full_out, 1);
      check(of_seen, of_exp);
      run(mbm_pkg::OP_RXMOV, 130, 'h200, 'h200, 0);
      check(rx_count_out, 0);
      check(rx_full_out, 0);
      for (i = 0; i < 30; i++) begin
         op = mbm_pkg::mbm_op_e'($urandom % 5);
         c = $urandom % 256;
         a = $urandom % 1024;
         e = $urandom % 1024;
         if (op == mbm_pkg::OP_REV && c > 16) e = (a + 512) % 1024;
         run(op, c, a, e, 1);
      end
      report_and_stop();
   end
endmodule
